// ---- design/adc_ddr_pkg.sv ----
// Package with types and constants for the DDR output and power control block.
package adc_ddr_pkg;

    // ==========================================================
    // Word and pipeline
    localparam int WORD_BITS = 12;
    localparam int HALF_BITS = 6;
    localparam int PIPE_FULL_CYCLES = 7;
    localparam int PIPE_DEPTH = PIPE_FULL_CYCLES + 1;
    localparam logic [WORD_BITS-1:0] CODE_MIN = 12'h000;
    localparam logic [WORD_BITS-1:0] CODE_MAX = 12'hfff;
    localparam logic [WORD_BITS-1:0] CODE_MID = 12'h800;
    localparam logic [WORD_BITS-1:0] MSB_MASK = 12'h800;

    // ==========================================================
    // Recovery times after leaving a low power state
    localparam int CLK_HZ = 10_000_000;
    localparam int PD_RECOVERY_US = 3000;
    localparam int SLEEP_RECOVERY_US = 100;
    localparam int PD_RECOVERY_CYCLES = PD_RECOVERY_US * (CLK_HZ / 1_000_000);
    localparam int SLEEP_RECOVERY_CYCLES = SLEEP_RECOVERY_US * (CLK_HZ / 1_000_000);
    localparam int RECOVERY_BITS = 16;

    // ==========================================================
    // Strap and power encodings
    localparam logic [1:0] STRAP_LEVEL_0 = 2'h0;
    localparam logic [1:0] STRAP_LEVEL_1 = 2'h1;
    localparam logic [1:0] STRAP_LEVEL_2 = 2'h2;
    localparam logic [1:0] STRAP_LEVEL_3 = 2'h3;
    localparam logic [1:0] PWR_LEVEL_GND = 2'h0;
    localparam logic [1:0] PWR_LEVEL_MID = 2'h1;
    localparam logic [1:0] PWR_LEVEL_HIGH = 2'h2;

    typedef enum logic {CLK_SINGLE, CLK_DIFF} clock_mode_t;
    typedef enum logic {FMT_OFFSET_BINARY, FMT_TWOS_COMPLEMENT} data_format_t;
    typedef enum {PWR_ON, PWR_SLEEP, PWR_DOWN, PWR_RECOVER} power_state_t;

    typedef struct packed {
        clock_mode_t clock_mode;
        data_format_t data_format;
    } strap_cfg_t;

    typedef struct packed {
        logic [HALF_BITS-1:0] odd_bits;
        logic [HALF_BITS-1:0] even_bits;
        logic strobe;
        logic valid;
    } ddr_out_t;

endpackage

// ---- design/adc_sample_front.sv ----
// Sample front end: saturating quantiser and number format conversion.
`timescale 1ns/10ps
module adc_sample_front
    import adc_ddr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic take_sample,
    input wire logic signed [WORD_BITS:0] analog_in,
    input wire data_format_t data_format,
    output logic [WORD_BITS-1:0] code_out
);

    typedef struct packed {
        logic [WORD_BITS-1:0] code;
    } front_state_t;

    front_state_t state_r;
    front_state_t state_nxt;

    // ==========================================================
    // Quantiser
    // Input is a signed value around mid scale; out-of-range values clamp.
    function automatic logic [WORD_BITS-1:0] quantise(input logic signed [WORD_BITS:0] v);
        logic signed [WORD_BITS+1:0] biased;
        biased = {v[WORD_BITS], v} + $signed({2'h0, CODE_MID});
        if (biased < 0) begin
            return CODE_MIN;
        end else if (biased > $signed({2'h0, CODE_MAX})) begin
            return CODE_MAX;
        end
        return biased[WORD_BITS-1:0];
    endfunction

    always_comb begin
        state_nxt = state_r;
        if (take_sample) begin
            state_nxt.code = quantise(analog_in);
            if (data_format == FMT_TWOS_COMPLEMENT) begin
                state_nxt.code = quantise(analog_in) ^ MSB_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= '{code: CODE_MID};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign code_out = state_r.code;

endmodule

// ---- design/adc_ddr_output.sv ----
// Top of the converter digital side: sampling, pipeline, DDR output and power control.
`timescale 1ns/10ps
// Overview of operation
// - Every sample taken yields one 12-bit output word.
// - One four-level strap selects both the clock input mode and the output number format.
// - A word strobe is driven with the data and toggles at the sample clock rate.
// - Each sample is taken at the falling edge of the sample clock.
// - Each word starts at a strobe falling edge seven and a half sample clocks after acquisition.
// - A high power-state input gives power-down and no valid words.
// - A mid-level power-state input gives sleep, or holds power-down if already down, and stops conversion output.
// - Recovery from sleep is shorter than recovery from power-down.
// - Offset binary has mid scale at 800 and two's complement inverts its top bit.
module adc_ddr_output
    import adc_ddr_pkg::*;
#(
    parameter int PD_RECOVERY = PD_RECOVERY_CYCLES,
    parameter int SLEEP_RECOVERY = SLEEP_RECOVERY_CYCLES,
    parameter logic [3:0] STRAP_CLOCK_DIFF = 4'h5,
    parameter logic [3:0] STRAP_TWOS = 4'h3
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_clock,
    input wire logic signed [WORD_BITS:0] analog_in,
    input wire logic [1:0] clock_and_format_strap,
    input wire logic [1:0] power_state_select,
    output ddr_out_t data_out,
    output clock_mode_t clock_mode,
    output data_format_t data_format,
    output logic converting
);

    typedef struct packed {
        logic [1:0] sclk_sync;
        logic sclk_prev;
        logic [1:0] strap_sync0;
        logic [1:0] strap_sync1;
        logic [1:0] pwr_sync0;
        logic [1:0] pwr_sync1;
        strap_cfg_t cfg;
        power_state_t pwr;
        logic [RECOVERY_BITS-1:0] recover_cnt;
        logic [PIPE_FULL_CYCLES-1:0][WORD_BITS-1:0] pipe;
        logic [PIPE_FULL_CYCLES-1:0] pipe_valid;
        ddr_out_t out;
    } top_state_t;

    top_state_t state_r;
    top_state_t state_nxt;
    logic sclk_s;
    logic fall_edge;
    logic rise_edge;
    logic take_sample;
    logic [WORD_BITS-1:0] sampled_code;

    // ==========================================================
    // Strap decoding
    function automatic strap_cfg_t decode_strap(input logic [1:0] level);
        strap_cfg_t c;
        c.clock_mode = STRAP_CLOCK_DIFF[level] ? CLK_DIFF : CLK_SINGLE;
        c.data_format = STRAP_TWOS[level] ? FMT_TWOS_COMPLEMENT : FMT_OFFSET_BINARY;
        return c;
    endfunction

    function automatic logic [HALF_BITS-1:0] pick_bits(input logic [WORD_BITS-1:0] w, input logic odd);
        logic [HALF_BITS-1:0] r;
        for (int i = 0; i < HALF_BITS; i++) begin
            r[i] = w[2 * i + (odd ? 1 : 0)];
        end
        return r;
    endfunction

    // ==========================================================
    // Edge detection on the sampled link clock
    // The link clock is slow against clk, so two flops plus an edge compare suffice.
    assign sclk_s = state_r.sclk_sync[1];
    assign fall_edge = state_r.sclk_prev && !sclk_s;
    assign rise_edge = !state_r.sclk_prev && sclk_s;
    assign take_sample = fall_edge && (state_r.pwr == PWR_ON || state_r.pwr == PWR_RECOVER);

    adc_sample_front u_front (
        .clk(clk),
        .reset(reset),
        .take_sample(take_sample),
        .analog_in(analog_in),
        .data_format(state_r.cfg.data_format),
        .code_out(sampled_code)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.sclk_sync = {state_r.sclk_sync[0], sample_clock};
        state_nxt.sclk_prev = sclk_s;
        state_nxt.strap_sync0 = clock_and_format_strap;
        state_nxt.strap_sync1 = state_r.strap_sync0;
        state_nxt.pwr_sync0 = power_state_select;
        state_nxt.pwr_sync1 = state_r.pwr_sync0;
        state_nxt.cfg = decode_strap(state_r.strap_sync1);

        // Power state handling.
        if (state_r.pwr_sync1 == PWR_LEVEL_HIGH) begin
            state_nxt.pwr = PWR_DOWN;
        end else if (state_r.pwr_sync1 == PWR_LEVEL_MID) begin
            if (state_r.pwr != PWR_DOWN) begin
                state_nxt.pwr = PWR_SLEEP;
            end
        end else if (state_r.pwr == PWR_DOWN) begin
            state_nxt.pwr = PWR_RECOVER;
            state_nxt.recover_cnt = RECOVERY_BITS'(PD_RECOVERY);
        end else if (state_r.pwr == PWR_SLEEP) begin
            state_nxt.pwr = PWR_RECOVER;
            state_nxt.recover_cnt = RECOVERY_BITS'(SLEEP_RECOVERY);
        end else if (state_r.pwr == PWR_RECOVER) begin
            if (state_r.recover_cnt <= RECOVERY_BITS'(1)) begin
                state_nxt.pwr = PWR_ON;
                state_nxt.recover_cnt = '0;
            end else begin
                state_nxt.recover_cnt = state_r.recover_cnt - RECOVERY_BITS'(1);
            end
        end

        // The pipeline advances once per sample clock; sample front updates on the falling edge.
        if (fall_edge) begin
            for (int i = PIPE_FULL_CYCLES - 1; i > 0; i--) begin
                state_nxt.pipe[i] = state_r.pipe[i-1];
                state_nxt.pipe_valid[i] = state_r.pipe_valid[i-1];
            end
            state_nxt.pipe[0] = sampled_code;
            state_nxt.pipe_valid[0] = take_sample;
        end

        // The strobe runs inverted to the sample clock, so a word can start half a cycle after a sampling edge.
        if (state_r.pwr == PWR_DOWN || state_r.pwr == PWR_SLEEP) begin
            state_nxt.out = '0;
            state_nxt.pipe_valid = '0;
        end else if (rise_edge) begin
            state_nxt.out.strobe = 1'b0;
            state_nxt.out.odd_bits = pick_bits(state_r.pipe[PIPE_FULL_CYCLES-1], 1'b1);
            state_nxt.out.even_bits = pick_bits(state_r.pipe[PIPE_FULL_CYCLES-1], 1'b0);
            state_nxt.out.valid = state_r.pipe_valid[PIPE_FULL_CYCLES-1] && state_r.pwr == PWR_ON;
        end else if (fall_edge) begin
            state_nxt.out.strobe = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= '{pwr: PWR_ON, cfg: '{CLK_SINGLE, FMT_OFFSET_BINARY}, default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign data_out = state_r.out;
    assign clock_mode = state_r.cfg.clock_mode;
    assign data_format = state_r.cfg.data_format;
    assign converting = (state_r.pwr == PWR_ON);

endmodule

// ---- verif/adc_ddr_monitor.sv ----
// Checker for the DDR output and power control block.
`timescale 1ns/10ps
module adc_ddr_monitor
    import adc_ddr_pkg::*;
#(
    parameter logic [3:0] STRAP_CLOCK_DIFF = 4'h5,
    parameter logic [3:0] STRAP_TWOS = 4'h3
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_clock,
    input wire logic [1:0] clock_and_format_strap,
    input wire logic [1:0] power_state_select,
    input wire ddr_out_t data_out,
    input wire clock_mode_t clock_mode,
    input wire data_format_t data_format,
    input wire logic converting
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_down_all_off: assert property (power_state_select == 2'h2 [*6] |-> !converting && data_out == '0)
        else $error("power down still drives output");
    a_sleep_no_words: assert property (power_state_select == 2'h1 [*6] |-> !converting && !data_out.valid)
        else $error("sleep still gives valid words");
    a_strap_decode: assert property ($stable(clock_and_format_strap) [*8] |->
        clock_mode == clock_mode_t'(STRAP_CLOCK_DIFF[clock_and_format_strap]) &&
        data_format == data_format_t'(STRAP_TWOS[clock_and_format_strap]))
        else $error("strap decode mismatch");
    a_strobe_tracks: assert property ($changed(data_out.strobe) && converting && $past(converting) |->
        data_out.strobe != $past(sample_clock, 3))
        else $error("strobe does not follow sample clock");
    a_data_on_low: assert property ($changed(data_out.odd_bits) && converting |-> !data_out.strobe)
        else $error("data changed while strobe high");
    a_valid_at_fall: assert property ($rose(data_out.valid) |-> !data_out.strobe && converting)
        else $error("valid rose outside a strobe fall");
    a_strobe_low_len: assert property ($fell(data_out.strobe) && converting |-> !data_out.strobe [*4])
        else $error("strobe low phase too short");
    a_strobe_high_len: assert property ($rose(data_out.strobe) |-> ##[1:4] !data_out.strobe)
        else $error("strobe high phase too long");
endmodule

// ---- verif/ddr_capture_model.sv ----
// Far-side capture logic that rebuilds words from the DDR halves.
`timescale 1ns/10ps
module ddr_capture_model
    import adc_ddr_pkg::*;
(
    input wire logic clk,
    input wire ddr_out_t data_out,
    output logic [WORD_BITS-1:0] word,
    output logic word_valid
);
    // ==========================================================
    // Capture
    logic strobe_r = 1'b0;
    logic valid_r = 1'b0;
    logic [HALF_BITS-1:0] odd_r = '0;
    logic [HALF_BITS-1:0] even_r = '0;
    initial word = '0;
    initial word_valid = 1'b0;
    // Data may change as the strobe falls, so even bits come from the cycle before.
    always @(posedge clk) begin
        strobe_r <= data_out.strobe;
        even_r <= data_out.even_bits;
        if (data_out.strobe && !strobe_r) begin
            odd_r <= data_out.odd_bits;
            valid_r <= data_out.valid;
        end
        if (!data_out.strobe && strobe_r) begin
            for (int i = 0; i < HALF_BITS; i++) begin
                word[2*i+1] <= odd_r[i];
                word[2*i] <= even_r[i];
            end
            word_valid <= valid_r;
        end
    end
endmodule

// ---- verif/adc_ddr_output_tb.sv ----
// Testbench for the DDR output and power control block.
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module adc_ddr_output_tb
    import adc_ddr_pkg::*;
;
    // ==========================================================
    // Setup
    localparam int PD_REC = 40;
    localparam int SLP_REC = 10;
    localparam logic [3:0] DIFF_MAP = 4'h5;
    localparam logic [3:0] TWOS_MAP = 4'h3;
    // The run is about 2700 cycles, so this only trips on a hang.
    localparam int LIMIT = 9000;
    logic clk;
    logic reset = 1'b1;
    logic sample_clock = 1'b1;
    logic signed [WORD_BITS:0] analog_in = '0;
    logic [1:0] clock_and_format_strap = 2'h0;
    logic [1:0] power_state_select = 2'h0;
    ddr_out_t data_out;
    clock_mode_t clock_mode;
    data_format_t data_format;
    logic converting;
    logic [WORD_BITS-1:0] word;
    logic word_valid;
    logic [1:0] ph = 2'h0;
    int falls = 0;
    int cycles = 0;
    int failures = 0;
    int check_count = 0;
    adc_ddr_output #(.PD_RECOVERY(PD_REC), .SLEEP_RECOVERY(SLP_REC), .STRAP_CLOCK_DIFF(DIFF_MAP),
        .STRAP_TWOS(TWOS_MAP)) u_dut (.clk, .reset, .sample_clock, .analog_in, .clock_and_format_strap,
        .power_state_select, .data_out, .clock_mode, .data_format, .converting);
    ddr_capture_model u_cap (.clk, .data_out, .word, .word_valid);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        cycles <= cycles + 1;
        if (ph == 2'h3) begin
            sample_clock <= ~sample_clock;
            falls <= falls + int'(sample_clock);
        end
        if (cycles == LIMIT) begin
            failures++;
            close_out();
        end
    end
    function automatic logic [11:0] expect_code(input int v, input logic twos);
        logic [11:0] c;
        c = (v > 2047) ? 12'hfff : (v < -2048) ? 12'h000 : 12'(v + 2048);
        return c ^ {twos, 11'h000};
    endfunction
    task automatic wait_falls(input int n);
        int f;
        f = falls;
        while (falls < f + n) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic format_test;
        int vals[6] = '{0, 1024, 2047, 4000, -2048, -4000};
        for (int l = 0; l < 4; l++) begin
            clock_and_format_strap <= 2'(l);
            for (int i = 0; i < 6; i++) begin
                analog_in <= 13'(vals[i]);
                wait_falls(12);
                `CHECK("word", expect_code(vals[i], TWOS_MAP[l]), word)
                `CHECK("word valid", 1'b1, word_valid)
            end
            `CHECK("clock mode", clock_mode_t'(DIFF_MAP[l]), clock_mode)
            `CHECK("format", data_format_t'(TWOS_MAP[l]), data_format)
        end
        $display("format test done");
    endtask
    task automatic latency_test;
        clock_and_format_strap <= 2'h2;
        analog_in <= 13'h0000;
        wait_falls(12);
        analog_in <= 13'h0400;
        wait_falls(9);
        `CHECK("old word", expect_code(0, TWOS_MAP[2]), word)
        wait_falls(1);
        `CHECK("new word", expect_code(1024, TWOS_MAP[2]), word)
        $display("latency test done");
    endtask
    task automatic power_test;
        int n[2];
        for (int k = 0; k < 2; k++) begin
            power_state_select <= k ? 2'h1 : 2'h2;
            wait_falls(2);
            `CHECK("converting", 1'b0, converting)
            `CHECK("valid", 1'b0, data_out.valid)
            power_state_select <= 2'h0;
            n[k] = 0;
            while (converting !== 1'b1 && n[k] < 2000) begin
                @(posedge clk);
                n[k]++;
            end
        end
        `CHECK("down wait", 1'b1, n[0] >= PD_REC)
        `CHECK("sleep wait", 1'b1, n[1] >= SLP_REC && n[1] < n[0])
        wait_falls(12);
        `CHECK("word after wake", expect_code(1024, TWOS_MAP[2]), word)
        `CHECK("valid after wake", 1'b1, word_valid)
        $display("power test done");
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        format_test();
        latency_test();
        power_test();
        close_out();
    end
endmodule
bind adc_ddr_output adc_ddr_monitor #(.STRAP_CLOCK_DIFF(STRAP_CLOCK_DIFF), .STRAP_TWOS(STRAP_TWOS)) u_mon (
    .clk, .reset, .sample_clock, .clock_and_format_strap, .power_state_select, .data_out, .clock_mode,
    .data_format, .converting);
